// file: sp_consts.svh
// Constants for the strap sampler: register offsets, field positions, reset values and codes
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH

`define SP_ADDR_W         4
`define SP_OFF_STATUS     4'h0
`define SP_OFF_CONTROL    4'h4
`define SP_OFF_CHARGE     4'h8

`define SP_ST_STRAPS_EN   0
`define SP_ST_SELF_PWR    1
`define SP_ST_CODE_LO     2
`define SP_ST_COMPOUND    4
`define SP_ST_CFG_DONE    5
`define SP_ST_LED_ON      6
`define SP_ST_CFG_SEL_LO  7
`define SP_ST_POWER_LO    16

`define SP_CTL_LOAD_DONE  0

`define SP_CFG_DEFAULT    2'h0
`define SP_CFG_SMBUS      2'h1
`define SP_CFG_BUS_PWR    2'h2
`define SP_CFG_EEPROM     2'h3

`define SP_CODE_RESET     2'h0
`define SP_CHARGE_RESET   32'h0
`define SP_SYNC_STAGES    2

`endif

// file: sp_pkg.sv
// Types shared by the strap sampler files
package sp_pkg;
  typedef logic [1:0] sp_code_type;
  typedef enum logic [1:0] {ST_CAPTURE, ST_WAIT_CFG, ST_RUN} sp_state_type;
endpackage : sp_pkg

// file: sp_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  // No reset: the chain must already carry the strap levels while reset is held
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : sp_sync2
`default_nettype wire

// file: sp_strap_top.sv
// Strap sampler with shared LED pin, self-power sense and port power control
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sp_consts.svh"

// Functional notes
// RULE1: The status LED is asserted only while the hub is configured and not suspended.
// RULE2: A low self-power detect level means bus powered, a high level means local supply present.
// RULE3: With straps enabled both fixed-port strap bits are captured when reset is released.
// RULE4: Fixed-port code 00 means none fixed, 01 port 1, 10 ports 1-2, 11 ports 1-3 where present.
// RULE5: The LED is active high for codes 00 and 10 and active low for codes 01 and 11.
// RULE6: The LED polarity comes from the strap value captured on the LED pin itself.
// RULE7: A pulled-up strap pin reads as option 1 and a pulled-down one as option 0.
// RULE8: Each charge-enable strap gives 1 when high and 0 when low, per port.
// RULE9: Strap levels set options only when the configuration method enables straps.
// RULE10: Serial-bus and EEPROM configuration methods disable every strap option.
// RULE11: Any fixed port makes the hub report itself as a compound device.
// RULE12: Each charge-enabled port has port power on as soon as configuration completes. Here port_power_out comes on one clock after config_complete rises.
// RULE13: Captured straps hold until the next reset and the shared pins then act only as function pins.
module sp_strap_top #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output var  logic [31:0]           avs_readdata,
  output var  logic                  avs_waitrequest,
  input  wire sp_pkg::sp_code_type   cfg_sel_pins,
  input  wire logic                  fixed_port_strap_bit0,
  output var  logic                  suspend_indicator_led,
  output var  logic                  suspend_indicator_led_oe,
  input  wire logic                  fixed_port_strap_bit1,
  input  wire logic                  self_power_detect,
  input  wire logic [NUM_PORTS-1:0]  charge_enable_straps,
  output var  logic [NUM_PORTS-1:0]  port_power_out,
  output var  logic [NUM_PORTS-1:0]  port_power_oe,
  input  wire logic                  hub_configured,
  input  wire logic                  hub_suspended,
  input  wire logic [NUM_PORTS-1:0]  port_power_req,
  output var  sp_pkg::sp_code_type   fixed_port_code,
  output var  logic [NUM_PORTS-1:0]  fixed_ports,
  output var  logic                  compound_device,
  output var  logic                  self_powered,
  output var  logic                  config_complete
);
  import sp_pkg::*;

  localparam int SW = NUM_PORTS + 5;

  function automatic logic strap_allowed(input sp_code_type cfg);
    strap_allowed = (cfg == `SP_CFG_DEFAULT) || (cfg == `SP_CFG_BUS_PWR); // see RULE9 see RULE10
  endfunction : strap_allowed

  function automatic logic [NUM_PORTS-1:0] decode_fixed(input sp_code_type code);
    logic [NUM_PORTS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      // Ports beyond the device's count simply drop out of the mask
      m[i] = (i < 3) && (32'(i) < 32'(code)); // see RULE4
    end
    decode_fixed = m;
  endfunction : decode_fixed

  logic [SW-1:0]        sync_q;
  logic                 b0_s;
  logic                 b1_s;
  logic                 self_s;
  sp_code_type          cfg_s;
  logic [NUM_PORTS-1:0] charge_s;

  sp_sync2 #(.W(SW)) u_sync (
    .clock (clock),
    .d     ({charge_enable_straps, cfg_sel_pins, self_power_detect, fixed_port_strap_bit1, fixed_port_strap_bit0}),
    .q     (sync_q)
  );

  assign b0_s     = sync_q[0];
  assign b1_s     = sync_q[1];
  assign self_s   = sync_q[2];
  assign cfg_s    = sync_q[4:3];
  assign charge_s = sync_q[SW-1:5];

  sp_state_type         state_q,   state_d;
  sp_code_type          code_q,    code_d;
  sp_code_type          cfgm_q,    cfgm_d;
  logic                 sen_q,     sen_d;
  logic [NUM_PORTS-1:0] chs_q,     chs_d;
  logic [NUM_PORTS-1:0] fixm_q,    fixm_d;
  logic                 led_q,     led_d;
  logic                 led_oe_q,  led_oe_d;
  logic [NUM_PORTS-1:0] pwr_q,     pwr_d;
  logic [NUM_PORTS-1:0] pwr_oe_q,  pwr_oe_d;
  logic                 comp_q,    comp_d;
  logic                 selfp_q,   selfp_d;
  logic                 done_q,    done_d;
  logic                 load_q,    load_d;
  logic [NUM_PORTS-1:0] chreg_q,   chreg_d;
  logic                 wait_q,    wait_d;
  logic [31:0]          rdata_q,   rdata_d;
  logic [NUM_PORTS-1:0] charge_eff;
  logic                 led_on;

  assign led_on     = hub_configured & ~hub_suspended; // see RULE1
  // Serial methods take charge enables from software, strap methods from the pins
  assign charge_eff = sen_q ? chs_q : chreg_q; // see RULE10

  // Strap capture and pin functions
  always_comb begin
    state_d  = state_q;
    code_d   = code_q;
    cfgm_d   = cfgm_q;
    sen_d    = sen_q;
    chs_d    = chs_q;
    unique case (state_q)
      ST_CAPTURE: begin
        cfgm_d  = cfg_s;
        sen_d   = strap_allowed(cfg_s); // see RULE9
        // High pin level is option 1, low is 0; ignored unless straps are on
        code_d  = sen_d ? {b1_s, b0_s} : `SP_CODE_RESET; // see RULE3 see RULE7 see RULE10
        chs_d   = sen_d ? charge_s : '0; // see RULE8
        state_d = sen_d ? ST_RUN : ST_WAIT_CFG;
      end
      ST_WAIT_CFG: begin
        if (load_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN; // see RULE13
      end
    endcase
    fixm_d   = decode_fixed(code_d); // see RULE4
    comp_d   = |code_d; // see RULE11
    // Pin 0 polarity follows its own captured level
    led_d    = led_on ^ code_q[0]; // see RULE5 see RULE6
    led_oe_d = (state_q != ST_CAPTURE); // see RULE13
    pwr_d    = (state_q == ST_RUN) ? (charge_eff | port_power_req) : '0; // see RULE12
    pwr_oe_d = (state_q != ST_CAPTURE) ? '1 : '0;
    selfp_d  = self_s; // see RULE2
    done_d   = (state_d == ST_RUN);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q  <= ST_CAPTURE;
      code_q   <= `SP_CODE_RESET;
      cfgm_q   <= `SP_CFG_DEFAULT;
      sen_q    <= 1'b0;
      chs_q    <= '0;
      fixm_q   <= '0;
      led_q    <= 1'b0;
      led_oe_q <= 1'b0;
      pwr_q    <= '0;
      pwr_oe_q <= '0;
      comp_q   <= 1'b0;
      selfp_q  <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      code_q   <= code_d;
      cfgm_q   <= cfgm_d;
      sen_q    <= sen_d;
      chs_q    <= chs_d;
      fixm_q   <= fixm_d;
      led_q    <= led_d;
      led_oe_q <= led_oe_d;
      pwr_q    <= pwr_d;
      pwr_oe_q <= pwr_oe_d;
      comp_q   <= comp_d;
      selfp_q  <= selfp_d;
      done_q   <= done_d;
    end
  end

  // Avalon slave: every access waits exactly one cycle, which keeps read data registered
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    load_d  = load_q;
    chreg_d = chreg_q;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = '0;
      unique case (avs_address)
        `SP_OFF_STATUS: begin
          rdata_d[`SP_ST_STRAPS_EN]                    = sen_q;
          rdata_d[`SP_ST_SELF_PWR]                     = selfp_q;
          rdata_d[`SP_ST_CODE_LO +: 2]                 = code_q;
          rdata_d[`SP_ST_COMPOUND]                     = comp_q;
          rdata_d[`SP_ST_CFG_DONE]                     = done_q;
          rdata_d[`SP_ST_LED_ON]                       = led_on;
          rdata_d[`SP_ST_CFG_SEL_LO +: 2]              = cfgm_q;
          rdata_d[`SP_ST_POWER_LO +: NUM_PORTS]        = pwr_q;
        end
        `SP_OFF_CONTROL: rdata_d[`SP_CTL_LOAD_DONE] = load_q;
        `SP_OFF_CHARGE:  rdata_d[NUM_PORTS-1:0]      = chreg_q;
        default:         rdata_d = '0;
      endcase
    end
    if (avs_write && !wait_q) begin
      // Load-done is write-one-to-set and holds to reset
      if (avs_address == `SP_OFF_CONTROL && avs_writedata[`SP_CTL_LOAD_DONE]) begin
        load_d = 1'b1;
      end
      if (avs_address == `SP_OFF_CHARGE) begin
        chreg_d = avs_writedata[NUM_PORTS-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      load_q  <= 1'b0;
      chreg_q <= NUM_PORTS'(`SP_CHARGE_RESET);
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      load_q  <= load_d;
      chreg_q <= chreg_d;
    end
  end

  assign avs_readdata             = rdata_q;
  assign avs_waitrequest          = wait_q;
  assign suspend_indicator_led    = led_q;
  assign suspend_indicator_led_oe = led_oe_q;
  assign port_power_out           = pwr_q;
  assign port_power_oe            = pwr_oe_q;
  assign fixed_port_code          = code_q;
  assign fixed_ports              = fixm_q;
  assign compound_device          = comp_q;
  assign self_powered             = selfp_q;
  assign config_complete          = done_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  led_state_a: assert property ((state_q != ST_CAPTURE) ##1 (state_q != ST_CAPTURE) |-> // see RULE1
    led_q == ($past(led_on) ^ code_q[0])) else $error("LED does not follow hub activity");
  led_polarity_a: assert property ((state_q == ST_RUN) && led_on |=> // see RULE5
    led_q == !code_q[0]) else $error("LED polarity wrong for code");
  self_power_a: assert property (##3 (selfp_q == $past(self_power_detect, 3))) // see RULE2
    else $error("Self power flag lags or inverts the pin");
  // Reset is synchronous: the release edge still resets, so a capture is only checked once rst is sampled low
  strap_capture_a: assert property (!rst && (state_q == ST_CAPTURE) && strap_allowed(cfg_s) |=> // see RULE3
    code_q == $past({b1_s, b0_s}) && chs_q == $past(charge_s)) else $error("Straps not captured");
  fixed_decode_a: assert property (fixm_q == decode_fixed(code_q)) // see RULE4
    else $error("Fixed port mask disagrees with code");
  strap_off_a: assert property (!rst && (state_q == ST_CAPTURE) && !strap_allowed(cfg_s) |=> // see RULE10
    code_q == 2'h0 && chs_q == '0 && state_q == ST_WAIT_CFG) else $error("Strap applied while disabled");
  compound_a: assert property (comp_q == (code_q != 2'h0)) // see RULE11
    else $error("Compound flag wrong");
  charge_power_a: assert property ((state_q == ST_RUN) |=> // see RULE12
    (pwr_q & $past(charge_eff)) == $past(charge_eff)) else $error("Charging port left unpowered");
  strap_hold_a: assert property ((state_q != ST_CAPTURE) |=> $stable(code_q) && $stable(sen_q)) // see RULE13
    else $error("Captured strap changed");
  bus_answer_a: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("Bus answer not one cycle");

  cover_code3_c: cover property ((state_q == ST_RUN) && (code_q == 2'h3) && led_on);
  cover_serial_c: cover property ((state_q == ST_WAIT_CFG) ##[1:1000] (state_q == ST_RUN));
  cover_power_c: cover property ((state_q == ST_RUN) && (pwr_q != '0));
endmodule : sp_strap_top
`default_nettype wire

// file: sp_board_model.sv
// Board model: strap resistors, shared LED pin, port power pins and local supply sense
`timescale 1ns/1ps
`default_nettype none
module sp_board_model #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic [1:0]           code_pull,
  input  wire logic [NUM_PORTS-1:0] charge_pull,
  input  wire logic                 supply_on,
  input  wire logic                 led_level,
  input  wire logic                 led_oe,
  input  wire logic [NUM_PORTS-1:0] pwr_level,
  input  wire logic [NUM_PORTS-1:0] pwr_oe,
  output var  logic                 strap_bit0,
  output var  logic                 strap_bit1,
  output var  logic [NUM_PORTS-1:0] charge_pins,
  output var  logic                 supply_sense
);
  // A released pin settles to its resistor level, never to the last driven value
  always_comb begin
    strap_bit0 = led_oe ? led_level : code_pull[0];
    strap_bit1 = code_pull[1];
    for (int i = 0; i < NUM_PORTS; i++) begin
      charge_pins[i] = pwr_oe[i] ? pwr_level[i] : charge_pull[i];
    end
    supply_sense = supply_on;
  end
endmodule : sp_board_model
`default_nettype wire

// file: test_strap_sample_led_polarity.sv
// Self-checking bench for the strap sampler
`timescale 1ns/1ps
`default_nettype none
`include "sp_consts.svh"
module test_strap_sample_led_polarity;
  import sp_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  sp_code_type cfg_sel_pins = 2'h0;
  sp_code_type code_pull = 2'h0;
  sp_code_type fixed_port_code;
  logic [3:0]  charge_pull = 4'h0;
  logic [3:0]  req = 4'h0;
  logic [3:0]  pins, ppo, ppoe, fixed_ports;
  logic        b0, b1, spd_pin, led, led_oe, compound, self_pwr, cfg_done;
  logic        spd = 1'b0;
  logic        hub_cfg = 1'b0;
  logic        hub_susp = 1'b0;
  int          n_tests = 0;
  int          n_fail = 0;

  always #10 clock = ~clock;

  sp_board_model #(.NUM_PORTS(4)) board (.code_pull(code_pull), .charge_pull(charge_pull), .supply_on(spd),
    .led_level(led), .led_oe(led_oe), .pwr_level(ppo), .pwr_oe(ppoe), .strap_bit0(b0), .strap_bit1(b1),
    .charge_pins(pins), .supply_sense(spd_pin));

  sp_strap_top #(.NUM_PORTS(4)) DUT (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_sel_pins(cfg_sel_pins), .fixed_port_strap_bit0(b0),
    .suspend_indicator_led(led), .suspend_indicator_led_oe(led_oe), .fixed_port_strap_bit1(b1),
    .self_power_detect(spd_pin), .charge_enable_straps(pins), .port_power_out(ppo), .port_power_oe(ppoe),
    .hub_configured(hub_cfg), .hub_suspended(hub_susp), .port_power_req(req), .fixed_port_code(fixed_port_code),
    .fixed_ports(fixed_ports), .compound_device(compound), .self_powered(self_pwr), .config_complete(cfg_done));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low; a stuck slave ends the run
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) begin
      n_fail++;
      test_done();
    end
  endtask : bus

  task automatic reset_with(input sp_code_type m, input sp_code_type c, input logic [3:0] chg, input logic [3:0] r);
    @(posedge clock);
    rst <= 1'b1;
    cfg_sel_pins <= m;
    code_pull <= c;
    charge_pull <= chg;
    req <= r;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : reset_with

  task automatic t_strap_codes();
    for (int c = 0; c < 4; c++) begin
      reset_with(2'h0, sp_code_type'(c), 4'ha, 4'h1);
      chk(32'(fixed_port_code), 32'(c));
      chk(32'(fixed_ports), (32'h1 << c) - 32'h1);
      chk(32'(compound), 32'(c != 0));
      chk(32'(ppo), 32'hb);
      chk(32'(led_oe), 32'h1);
      chk(32'(ppoe), 32'hf);
      chk(32'(led), 32'(c[0]));
      hub_cfg <= 1'b1;
      hub_susp <= 1'b0;
      repeat (3) @(posedge clock);
      chk(32'(led), 32'(!c[0]));
      hub_susp <= 1'b1;
      repeat (3) @(posedge clock);
      chk(32'(led), 32'(c[0]));
      hub_cfg <= 1'b0;
    end
  endtask : t_strap_codes

  task automatic t_cfg_modes();
    logic [31:0] rd;
    logic        on;
    for (int m = 1; m < 4; m++) begin
      on = (m == 2);
      reset_with(sp_code_type'(m), 2'h3, 4'hf, 4'h0);
      chk(32'(fixed_port_code), on ? 32'h3 : 32'h0);
      chk(32'(ppo), on ? 32'hf : 32'h0);
      chk(32'(cfg_done), 32'(on));
      bus(1'b0, `SP_OFF_STATUS, 32'h0, rd);
      chk(32'(rd[`SP_ST_STRAPS_EN]), 32'(on));
      if (!on) begin
        bus(1'b1, `SP_OFF_CHARGE, 32'h5, rd);
        bus(1'b1, `SP_OFF_CONTROL, 32'h1, rd);
        repeat (3) @(posedge clock);
        chk(32'(cfg_done), 32'h1);
        chk(32'(ppo), 32'h5);
      end
    end
  endtask : t_cfg_modes

  task automatic t_hold_and_sense();
    logic [31:0] rd;
    reset_with(2'h0, 2'h2, 4'h0, 4'h0);
    code_pull <= 2'h1;
    spd <= 1'b1;
    repeat (5) @(posedge clock);
    chk(32'(fixed_port_code), 32'h2);
    chk(32'(self_pwr), 32'h1);
    spd <= 1'b0;
    repeat (5) @(posedge clock);
    bus(1'b0, `SP_OFF_STATUS, 32'h0, rd);
    chk(32'(rd[`SP_ST_SELF_PWR]), 32'h0);
    chk(32'(rd[`SP_ST_CODE_LO+1:`SP_ST_CODE_LO]), 32'h2);
    bus(1'b1, 4'hc, 32'hffff, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : t_hold_and_sense

  initial begin
    t_strap_codes();
    t_cfg_modes();
    t_hold_and_sense();
    test_done();
  end
endmodule : test_strap_sample_led_polarity
`default_nettype wire
